// File: logic/drive_seq_pkg.sv
/*
 * drive_seq_pkg: shared types, state encoding and timing constants for the
 * motor on/off sequencer and its input debounce filter.
 * assumes: one 40 MHz system clock; speeds are signed fixed-point rpm * 100.
 */
package drive_seq_pkg;

    // -------------------------------------------------------------------
    // clock and timing
    // -------------------------------------------------------------------
    localparam int unsigned CLK_HZ             = 40_000_000;  // system clock rate
    localparam int unsigned PULSE_CANCEL_MS    = 10;          // 0.01 s pulse cancel delay
    localparam int unsigned STANDSTILL_MON_S   = 300;         // 300.00 s monitor time
    localparam int unsigned TICK_HZ            = 1000;        // millisecond tick rate
    localparam int unsigned TICK_DIV           = CLK_HZ / TICK_HZ;  // clocks per tick
    // monitor time expressed in ticks, derived from its seconds figure
    localparam int unsigned STANDSTILL_MON_MS  = STANDSTILL_MON_S * 1000;
    localparam int unsigned DEBOUNCE_MS_RST    = 0;           // debounce off after reset

    // -------------------------------------------------------------------
    // speeds, in hundredths of rpm
    // -------------------------------------------------------------------
    localparam logic [15:0] STANDSTILL_SPEED_RST = 16'h07d0;  // 20.00 rpm

    // -------------------------------------------------------------------
    // widths
    // -------------------------------------------------------------------
    localparam int unsigned NUM_DI    = 6;                    // digital inputs
    localparam int unsigned SEL_W     = 3;                    // source select width
    localparam int unsigned TICK_W    = 16;                   // tick divider width
    localparam int unsigned TIMER_W   = 20;                   // ms timers

    // index of the two inputs paired into the fail-safe channel
    localparam int unsigned DI_FS_A   = 4;
    localparam int unsigned DI_FS_B   = 5;

    // -------------------------------------------------------------------
    // sequencer states, gray along the on path
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        SWITCH_ON_INHIBITED = 3'h0,
        READY_TO_START      = 3'h1,
        AWAIT_ENABLE        = 3'h3,
        RUNNING             = 3'h2,
        RAMP_STOP_A         = 3'h6,
        QUICK_STOP          = 3'h7,
        RAMP_STOP_C         = 3'h5
    } seq_state_t;

    // ramp selection shown to the ramp generator
    typedef enum logic [1:0] {
        RAMP_NONE  = 2'h0,
        RAMP_NORM  = 2'h1,
        RAMP_QUICK = 2'h2
    } ramp_sel_t;

    // command sources from the controller (besides the selected on input)
    typedef struct packed {
        logic jog1;
        logic jog2;
        logic coastStopN;   // low requests coast stop
        logic quickStopN;   // low requests quick stop
        logic enableOp;     // operation enable
    } cmd_t;

    // drive status outputs
    typedef struct packed {
        seq_state_t state;
        logic       energised;
        ramp_sel_t  ramp;
        logic       standstill;
        logic       safeTorqueOff;
    } drive_status_t;

endpackage : drive_seq_pkg

// File: logic/input_debounce.sv
/*
 * input_debounce: per-bit debounce of digital inputs.
 * assumes: inputs synchronous to clk; tick is a one-cycle millisecond enable.
 */
`timescale 1ns/1ps
module input_debounce #(
    parameter int unsigned WIDTH = drive_seq_pkg::NUM_DI,
    parameter int unsigned CNT_W = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             tick,
    input  wire logic [CNT_W-1:0] debounceMs,
    input  wire logic [WIDTH-1:0] rawIn,
    output logic      [WIDTH-1:0] filtered
);
    import drive_seq_pkg::*;

    // -------------------------------------------------------------------
    // per-bit filter: output follows input once stable for debounceMs ticks
    // -------------------------------------------------------------------
    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_bit
            typedef struct packed {
                logic             out;
                logic [CNT_W-1:0] cnt;
            } deb_t;
            deb_t st_r;   // registered state
            deb_t st_nxt; // next state

            // count stable ticks while input differs; zero time passes through
            always_comb begin
                st_nxt = st_r;
                if (rawIn[i] == st_r.out) begin
                    st_nxt.cnt = '0;
                end else if (debounceMs == '0) begin
                    st_nxt.out = rawIn[i];
                end else if (tick) begin
                    if (st_r.cnt + 1'b1 >= debounceMs) begin
                        st_nxt.out = rawIn[i];
                        st_nxt.cnt = '0;
                    end else begin
                        st_nxt.cnt = st_r.cnt + 1'b1;
                    end
                end
            end

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    st_r <= '0;
                end else begin
                    st_r <= st_nxt;
                end
            end

            assign filtered[i] = st_r.out;
        end
    endgenerate

endmodule : input_debounce

// File: logic/drive_on_off_sequencer.sv
/*
 * drive_on_off_sequencer: on/off sequence control of a motor inverter.
 * assumes: all inputs synchronous to clk; speeds in hundredths of rpm;
 * the ramp generator itself and the safety logic sit outside.
 */
`timescale 1ns/1ps
module drive_on_off_sequencer
    import drive_seq_pkg::*;
#(
    parameter int unsigned PULSE_TICKS = PULSE_CANCEL_MS,    // ms ticks
    parameter int unsigned MON_TICKS   = STANDSTILL_MON_MS,  // ms ticks
    parameter int unsigned CLK_DIV     = TICK_DIV            // clocks per ms
) (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic [NUM_DI-1:0]            digitalInputRaw,   // terminal inputs
    input  wire logic [SEL_W-1:0]             onCmdSourceSelect, // input feeding on/ramp stop
    input  wire logic [7:0]                   inputDebounceTime, // ms, 0 = off
    input  wire drive_seq_pkg::cmd_t          cmdIn,             // other commands
    input  wire logic                         enableOpSourceFixed, // 1: enable always on
    input  wire logic                         safeTorqueOffEnable, // function enabled
    input  wire logic signed [15:0]           speedActual,
    input  wire logic signed [15:0]           speedSetpoint,
    input  wire logic [15:0]                  standstillSpeedThreshold,
    output drive_seq_pkg::drive_status_t      status,
    output logic [NUM_DI-1:0]                 digitalInputStatus,
    output logic                              failsafeInputZero
);
    import drive_seq_pkg::*;

    // -------------------------------------------------------------------
    // millisecond tick divider
    // -------------------------------------------------------------------
    localparam logic [TICK_W-1:0] DIV_LAST = TICK_W'(CLK_DIV - 1);

    // whole module state in one struct
    typedef struct packed {
        logic [TICK_W-1:0]  divCnt;      // tick prescaler
        logic               tick;        // one-cycle ms enable
        seq_state_t         state;       // sequencer state
        logic               onPrev;      // last on command, for edge detect
        logic               energised;   // motor current flowing
        ramp_sel_t          ramp;        // active ramp
        logic [TIMER_W-1:0] pulseTmr;    // actual-speed path timer
        logic [TIMER_W-1:0] monTmr;      // setpoint path timer
        logic               standstill;  // standstill declared
        logic               safe_torque_off;         // safe torque off selected
        logic [NUM_DI-1:0]  diStatus;    // debounced inputs, registered
        logic               fdi;         // failsafe channel
    } seq_t;

    seq_t st_r;    // registered state
    seq_t st_nxt;  // next state

    logic [NUM_DI-1:0] diFiltered;  // debounce output
    logic              onCmd;       // selected on/ramp stop level
    logic              onRise;      // fresh on edge
    logic              wantOn;      // any switch-on request
    logic              enableOp;    // effective operation enable
    logic              rampStop;    // on released
    logic              coastStop;
    logic              quickStop;
    logic [15:0]       actAbs;      // |actual speed|
    logic [15:0]       setAbs;      // |setpoint|
    logic              actLow;
    logic              setLow;
    logic              stopping;    // in a braking state

    // -------------------------------------------------------------------
    // debounce filter
    // -------------------------------------------------------------------
    input_debounce #(
        .WIDTH (NUM_DI),
        .CNT_W (8)
    ) u_debounce (
        .clk        (clk),
        .rst        (rst),
        .tick       (st_r.tick),
        .debounceMs (inputDebounceTime),
        .rawIn      (digitalInputRaw),
        .filtered   (diFiltered)
    );

    // -------------------------------------------------------------------
    // command decode
    // -------------------------------------------------------------------
    // on source picked from any debounced status bit; out of range reads 0
    always_comb begin
        onCmd = 1'b0;
        if (onCmdSourceSelect < SEL_W'(NUM_DI)) begin
            onCmd = st_r.diStatus[onCmdSourceSelect];
        end
        onRise    = onCmd & ~st_r.onPrev;
        wantOn    = onCmd | cmdIn.jog1 | cmdIn.jog2;
        enableOp  = enableOpSourceFixed | cmdIn.enableOp;
        coastStop = ~cmdIn.coastStopN | st_r.safe_torque_off;      // torque off acts as coast
        quickStop = ~cmdIn.quickStopN;
        rampStop  = ~wantOn;
        actAbs    = speedActual[15] ? 16'(-speedActual) : speedActual;
        setAbs    = speedSetpoint[15] ? 16'(-speedSetpoint) : speedSetpoint;
        actLow    = actAbs < standstillSpeedThreshold;
        setLow    = setAbs < standstillSpeedThreshold;
        stopping  = (st_r.state == RAMP_STOP_A) || (st_r.state == RAMP_STOP_C)
                    || (st_r.state == QUICK_STOP);
    end

    // -------------------------------------------------------------------
    // next-state logic
    // -------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;

        // ms tick divider
        st_nxt.tick = 1'b0;
        if (st_r.divCnt >= DIV_LAST) begin
            st_nxt.divCnt = '0;
            st_nxt.tick   = 1'b1;
        end else begin
            st_nxt.divCnt = st_r.divCnt + 1'b1;
        end

        st_nxt.diStatus = diFiltered;
        st_nxt.onPrev   = onCmd;

        // failsafe channel is active only when both paired inputs agree high
        st_nxt.fdi = diFiltered[DI_FS_A] & diFiltered[DI_FS_B];
        // torque off is folded into the coast-stop path of the sequencer
        // selecting torque off needs the function enabled by the user
        st_nxt.safe_torque_off = safeTorqueOffEnable & ~st_nxt.fdi;

        // timers saturate at their end value, so a long stop never wraps to zero
        // standstill timers only run while braking; reset when condition drops
        if (!stopping || !actLow) begin
            st_nxt.pulseTmr = '0;
        end else if (st_r.tick && st_r.pulseTmr < TIMER_W'(PULSE_TICKS)) begin
            st_nxt.pulseTmr = st_r.pulseTmr + 1'b1;
        end
        if (!stopping || !setLow) begin
            st_nxt.monTmr = '0;
        end else if (st_r.tick && st_r.monTmr < TIMER_W'(MON_TICKS)) begin
            st_nxt.monTmr = st_r.monTmr + 1'b1;
        end
        st_nxt.standstill = stopping && ((st_r.pulseTmr >= TIMER_W'(PULSE_TICKS))
                            || (st_r.monTmr >= TIMER_W'(MON_TICKS)));

        // sequencer
        case (st_r.state)
            SWITCH_ON_INHIBITED: begin
                // go to await enable only on a fresh rising on, or to ready to start once no on is requested, while no stop pends
                if (onRise && !coastStop && !quickStop) begin
                    st_nxt.state = AWAIT_ENABLE;
                end else if (!wantOn && !coastStop && !quickStop) begin
                    st_nxt.state = READY_TO_START;
                end
            end
            READY_TO_START: begin
                st_nxt.energised = 1'b0;
                if (coastStop || quickStop) begin
                    st_nxt.state = SWITCH_ON_INHIBITED;
                end else if (wantOn) begin
                    st_nxt.state = AWAIT_ENABLE;
                end
            end
            AWAIT_ENABLE: begin
                if (coastStop || quickStop) begin
                    st_nxt.state = SWITCH_ON_INHIBITED;
                end else if (!wantOn) begin
                    st_nxt.state = READY_TO_START;
                end else if (enableOp) begin
                    st_nxt.state     = RUNNING;
                    st_nxt.energised = 1'b1;
                end
            end
            RUNNING: begin
                // stop priority: coast, then quick, then ramp
                if (coastStop) begin
                    st_nxt.state     = SWITCH_ON_INHIBITED;
                    st_nxt.energised = 1'b0;
                    st_nxt.ramp      = RAMP_NONE;
                end else if (quickStop) begin
                    st_nxt.state = QUICK_STOP;
                    st_nxt.ramp  = RAMP_QUICK;
                end else if (rampStop) begin
                    st_nxt.state = RAMP_STOP_A;
                    st_nxt.ramp  = RAMP_NORM;
                end else if (!enableOp) begin
                    st_nxt.state = RAMP_STOP_C;                  // inhibit operation
                    st_nxt.ramp  = RAMP_NORM;
                end else begin
                    st_nxt.ramp = RAMP_NONE;
                end
            end
            RAMP_STOP_A, RAMP_STOP_C: begin
                if (coastStop) begin
                    st_nxt.state     = SWITCH_ON_INHIBITED;
                    st_nxt.energised = 1'b0;
                    st_nxt.ramp      = RAMP_NONE;
                end else if (quickStop) begin
                    st_nxt.state = QUICK_STOP;
                    st_nxt.ramp  = RAMP_QUICK;
                end else if (st_r.standstill) begin
                    st_nxt.state     = READY_TO_START;
                    st_nxt.energised = 1'b0;
                    st_nxt.ramp      = RAMP_NONE;
                end else if (wantOn && enableOp && st_r.state == RAMP_STOP_A) begin
                    st_nxt.state = RUNNING;                      // re-on during ramp
                    st_nxt.ramp  = RAMP_NONE;
                end
            end
            QUICK_STOP: begin
                if (coastStop) begin
                    st_nxt.state     = SWITCH_ON_INHIBITED;
                    st_nxt.energised = 1'b0;
                    st_nxt.ramp      = RAMP_NONE;
                end else if (st_r.standstill) begin
                    // quick stop ends locked out until on is renewed
                    st_nxt.state     = SWITCH_ON_INHIBITED;
                    st_nxt.energised = 1'b0;
                    st_nxt.ramp      = RAMP_NONE;
                end
            end
            default: begin
                st_nxt.state     = READY_TO_START;
                st_nxt.energised = 1'b0;
                st_nxt.ramp      = RAMP_NONE;
            end
        endcase
    end

    // -------------------------------------------------------------------
    // state register; power-up lands in ready to start
    // -------------------------------------------------------------------
    // the divider restarts with reset, so the first tick lands CLK_DIV clocks later
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r       <= '0;
            st_r.state <= READY_TO_START;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flip-flops
    assign status.state         = st_r.state;
    assign status.energised     = st_r.energised;
    assign status.ramp          = st_r.ramp;
    assign status.standstill    = st_r.standstill;
    assign status.safeTorqueOff = st_r.safe_torque_off;
    assign digitalInputStatus   = st_r.diStatus;
    assign failsafeInputZero    = st_r.fdi;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    AST_RESET_READY: assert property (@(posedge clk)
        $fell(rst) |-> st_r.state == READY_TO_START)
        else $error("not ready to start after reset");

    AST_ON_RUNS: assert property (@(posedge clk) disable iff (rst)
        st_r.state == AWAIT_ENABLE && st_nxt.state == RUNNING |=> st_r.energised)
        else $error("running without energised motor");

    AST_READY_OFF: assert property (@(posedge clk) disable iff (rst)
        st_r.state == READY_TO_START |-> !st_r.energised)
        else $error("motor energised in ready to start");

    AST_INHIBIT_EDGE: assert property (@(posedge clk) disable iff (rst)
        st_r.state == SWITCH_ON_INHIBITED && wantOn && !onRise |=> st_r.state != AWAIT_ENABLE)
        else $error("left inhibited without fresh on");

    AST_COAST_NOW: assert property (@(posedge clk) disable iff (rst)
        st_r.energised && coastStop |=> !st_r.energised)
        else $error("coast stop did not de-energise");

    AST_QUICK_RAMP: assert property (@(posedge clk) disable iff (rst)
        st_r.state == QUICK_STOP |-> st_r.ramp == RAMP_QUICK && st_r.energised)
        else $error("quick stop without quick ramp");

    AST_STOP_ENERGISED: assert property (@(posedge clk) disable iff (rst)
        stopping && !st_r.standstill && !coastStop |=> st_r.energised)
        else $error("de-energised before standstill");

    AST_PULSE_PATH: assert property (@(posedge clk) disable iff (rst)
        st_r.pulseTmr >= TIMER_W'(PULSE_TICKS) && stopping |=> st_r.standstill)
        else $error("standstill missed after cancel delay");

    AST_TIMER_RESTART: assert property (@(posedge clk) disable iff (rst)
        !actLow |=> st_r.pulseTmr == '0)
        else $error("cancel timer kept counting");

    AST_FDI_PAIR: assert property (@(posedge clk) disable iff (rst)
        st_r.fdi |-> $past(diFiltered[DI_FS_A]) && $past(diFiltered[DI_FS_B]))
        else $error("failsafe input set without both inputs");

    // stop states: ramp choice, stop priority and the monitor standstill path
    // enable gating and torque-off qualification
    AST_RAMP_NORMAL: assert property (@(posedge clk) disable iff (rst)
        (st_r.state == RAMP_STOP_A || st_r.state == RAMP_STOP_C) |-> st_r.ramp == RAMP_NORM && st_r.energised)
        else $error("ramp stop without normal ramp");

    AST_AWAIT_HOLD: assert property (@(posedge clk) disable iff (rst)
        st_r.state == AWAIT_ENABLE && !enableOp |=> st_r.state != RUNNING && !st_r.energised)
        else $error("left await enable without enable");

    AST_QUICK_OVER_RAMP: assert property (@(posedge clk) disable iff (rst)
        st_r.state == RUNNING && quickStop && !coastStop |=> st_r.state == QUICK_STOP)
        else $error("quick stop did not take priority");

    AST_RAMP_DONE: assert property (@(posedge clk) disable iff (rst)
        st_r.state == RAMP_STOP_A && st_r.standstill && !coastStop && !quickStop
        |=> st_r.state == READY_TO_START && !st_r.energised)
        else $error("finished ramp stop not back in ready");

    AST_MON_PATH: assert property (@(posedge clk) disable iff (rst)
        st_r.monTmr >= TIMER_W'(MON_TICKS) && stopping |=> st_r.standstill)
        else $error("standstill missed after monitor time");

    AST_STILL_BRAKING: assert property (@(posedge clk) disable iff (rst)
        st_r.standstill |-> $past(stopping))
        else $error("standstill declared outside a stop");

    AST_STO_ENABLED: assert property (@(posedge clk) disable iff (rst)
        st_r.safe_torque_off |-> $past(safeTorqueOffEnable))
        else $error("torque off selected while function disabled");

endmodule : drive_on_off_sequencer

// File: sim/motor_ctrl_model.sv
/*
 * motor_ctrl_model: controller setpoint and motor shaft seen by the sequencer.
 * assumes: status comes from the sequencer; one clock, async reset.
 */
`timescale 1ns/1ps
module motor_ctrl_model
    import drive_seq_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire drive_seq_pkg::drive_status_t  status,
    input  wire logic                          stuck,
    output logic signed [15:0]                 speedActual,
    output logic signed [15:0]                 speedSetpoint
);
    // shaft speed falls while braking; stuck models a blocked ramp
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            speedActual <= 16'sh0000;
        end else if (status.state == RUNNING) begin
            speedActual <= 16'sh0bb8;
        end else if (status.ramp != RAMP_NONE && !stuck && speedActual > 0) begin
            speedActual <= speedActual - 16'sh0064;
        end
    end
    // setpoint drops to zero as soon as a stop is under way
    assign speedSetpoint = (status.state == RUNNING) ? 16'sh0bb8 : 16'sh0000;
endmodule : motor_ctrl_model

// File: sim/test_drive_on_off_sequencer.sv
/*
 * test_drive_on_off_sequencer: self-checking bench for the sequencer.
 * assumes: short tick parameters; inputs driven on the falling edge.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin failures++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_drive_on_off_sequencer;
    import drive_seq_pkg::*;
    logic clk = 1'b0, rst = 1'b1, stuck = 1'b0;
    logic [5:0] raw = 6'h00;
    logic [2:0] sel = 3'h2;
    logic [7:0] dbMs = 8'h00;
    cmd_t cmdIn = cmd_t'(5'h07);
    logic enFixed = 1'b1, stoEn = 1'b0;
    logic signed [15:0] spdAct, spdSet;
    drive_status_t status;
    logic [5:0] diStat;
    logic fsZero;
    int failures = 0, nChecks = 0;
    always #12.5 clk = ~clk;
    drive_on_off_sequencer #(.PULSE_TICKS(2), .MON_TICKS(40), .CLK_DIV(4)) DUT (
        .clk(clk), .rst(rst), .digitalInputRaw(raw), .onCmdSourceSelect(sel),
        .inputDebounceTime(dbMs), .cmdIn(cmdIn), .enableOpSourceFixed(enFixed),
        .safeTorqueOffEnable(stoEn), .speedActual(spdAct), .speedSetpoint(spdSet),
        .standstillSpeedThreshold(16'h07d0), .status(status),
        .digitalInputStatus(diStat), .failsafeInputZero(fsZero));
    motor_ctrl_model partner (.clk(clk), .rst(rst), .status(status), .stuck(stuck),
        .speedActual(spdAct), .speedSetpoint(spdSet));
    // expected fail-safe channel: both paired inputs high
    function automatic logic expFs(input logic [5:0] d);
        return d[4] & d[5];
    endfunction : expFs
    task automatic stop_test();
        $display("checks=%0d failures=%0d", nChecks, failures);
        if (failures == 0 && nChecks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    // bounded wait for a state, sampled at the falling edge
    task automatic waitFor(input seq_state_t s);
        int i;
        for (i = 0; i < 300 && status.state !== s; i++) @(negedge clk);
        `CHK(status.state, s)
    endtask : waitFor
    // fresh on edge on the selected input
    task automatic onEdge();
        raw[2] = 1'b0;
        repeat (4) @(negedge clk);
        raw[2] = 1'b1;
        waitFor(RUNNING);
    endtask : onEdge
    // watchdog, far beyond the expected run
    initial begin
        #500us;
        failures++;
        stop_test();
    end
    initial begin
        void'($urandom(60900));
        repeat (2) @(negedge clk);
        rst = 1'b0;
        `CHK(status.state, READY_TO_START)
        `CHK(status.energised, 1'b0)
        raw[2] = 1'b1;
        waitFor(RUNNING);
        `CHK(status.energised, 1'b1)
        raw[2] = 1'b0;
        waitFor(RAMP_STOP_A);
        `CHK(status.ramp, RAMP_NORM)
        repeat (3) @(negedge clk);
        `CHK(status.energised, 1'b1)
        `CHK(status.standstill, 1'b0)
        // the shaft path must end the stop long before the monitor timer could
        for (int i = 0; i < 25 && status.standstill !== 1'b1; i++) @(negedge clk);
        `CHK(status.standstill, 1'b1)
        `CHK(status.energised, 1'b1)
        waitFor(READY_TO_START);
        `CHK(status.energised, 1'b0)
        // quick stop with a blocked shaft: only the monitor path ends it
        onEdge();
        stuck = 1'b1;
        cmdIn.quickStopN = 1'b0;
        waitFor(QUICK_STOP);
        `CHK(status.ramp, RAMP_QUICK)
        waitFor(SWITCH_ON_INHIBITED);
        cmdIn.quickStopN = 1'b1;
        stuck = 1'b0;
        repeat (10) @(negedge clk);
        `CHK(status.state, SWITCH_ON_INHIBITED)
        onEdge();
        // coast and quick together: coast wins, no ramp
        cmdIn.coastStopN = 1'b0;
        cmdIn.quickStopN = 1'b0;
        repeat (3) @(negedge clk);
        `CHK(status.energised, 1'b0)
        `CHK(status.state, SWITCH_ON_INHIBITED)
        cmdIn.coastStopN = 1'b1;
        cmdIn.quickStopN = 1'b1;
        onEdge();
        // enable taken from the command port, then withdrawn
        enFixed = 1'b0;
        cmdIn.enableOp = 1'b0;
        waitFor(RAMP_STOP_C);
        `CHK(status.ramp, RAMP_NORM)
        raw[2] = 1'b0;
        waitFor(READY_TO_START);
        cmdIn.enableOp = 1'b1;
        cmdIn.jog1 = 1'b1;
        waitFor(RUNNING);
        cmdIn.jog1 = 1'b0;
        cmdIn.coastStopN = 1'b0;
        waitFor(SWITCH_ON_INHIBITED);
        cmdIn.coastStopN = 1'b1;
        // torque off must be enabled before the fail-safe input acts
        stoEn = 1'b1;
        raw[5:4] = 2'h3;
        onEdge();
        `CHK(fsZero, 1'b1)
        `CHK(status.safeTorqueOff, 1'b0)
        raw[4] = 1'b0;
        repeat (6) @(negedge clk);
        `CHK(status.energised, 1'b0)
        `CHK(status.safeTorqueOff, 1'b1)
        `CHK(fsZero, 1'b0)
        // debounce holds a new level back for about 2 ticks, 8 clocks with CLK_DIV of 4
        dbMs = 8'h02;
        raw[0] = 1'b1;
        repeat (4) @(negedge clk);
        `CHK(diStat[0], 1'b0)
        repeat (20) @(negedge clk);
        `CHK(diStat[0], 1'b1)
        dbMs = 8'h00;
        // random input patterns and source selects
        repeat (20) begin
            raw = 6'($urandom);
            sel = 3'($urandom_range(0, 7));
            repeat (3) @(negedge clk);
            `CHK(diStat, raw)
            `CHK(fsZero, expFs(raw))
        end
        stop_test();
    end
endmodule : test_drive_on_off_sequencer
